// [logic/mfo_defines.svh]
// Offsets, field positions, reset values and timing counts of the MAC frame option block
`ifndef MFO_DEFINES_SVH
`define MFO_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets (configuration and gap alias in bits 3:2)
// ----------------------------------------------------------------
`define MFO_OFS_CFG        6'h00
`define MFO_OFS_GAP        6'h10
`define MFO_OFS_IRQ_STAT   6'h20
`define MFO_OFS_IRQ_MASK   6'h24

// ----------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------
`define MFO_B_DEFER_NOLIM  14
`define MFO_B_BP_SKIP      13
`define MFO_B_COL_SKIP     12
`define MFO_B_PRE_LEN      9
`define MFO_B_PRE_PURE     8
`define MFO_B_PAD_DETECT   7
`define MFO_B_PAD_TAGGED   6
`define MFO_B_PAD_ON       5
`define MFO_B_CRC_ON       4
`define MFO_B_DUPLEX       0

// ----------------------------------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------------------------------
`define MFO_CFG_RESET      32'h0000_40B2
`define MFO_CFG_IMPL       32'h0000_73FF
`define MFO_GAP_RESET      32'h0000_0012
`define MFO_GAP_IMPL       32'h0000_007F
`define MFO_IRQ_IMPL       32'h0000_0007

// ----------------------------------------------------------------
// Frame constants
// ----------------------------------------------------------------
`define MFO_PRE_OCTET      8'h55
`define MFO_PRE_MAX_LEN    4'hC
`define MFO_TAG_HI         8'h81
`define MFO_TAG_LO         8'h00
`define MFO_TAG_POS_HI     4'hC
`define MFO_TAG_POS_LO     4'hD
`define MFO_GAP_ADD_FULL   8'h03
`define MFO_GAP_ADD_HALF   8'h06

`endif

// [logic/mfo_pkg.sv]
// Types shared by the MAC frame option block
package mfo_pkg;

    // Register alias selected by address bits 3:2
    typedef enum logic [1:0] {
        MFO_AL_WRITE = 2'b00,
        MFO_AL_CLEAR = 2'b01,
        MFO_AL_SET   = 2'b10,
        MFO_AL_INV   = 2'b11
    } mfo_alias_e;

    // Padding behaviour handed to the transmit path
    typedef enum logic [1:0] {
        MFO_PAD_NONE     = 2'b00,
        MFO_PAD_UNTAGGED = 2'b01,
        MFO_PAD_TAGGED   = 2'b10
    } mfo_pad_e;

    // Transmit-side events from the MAC core
    typedef struct packed {
        logic       defer_limit;
        logic       collision;
        logic       backpressure;
        logic       sof;
        logic       eof;
        logic       byte_valid;
        logic [7:0] byte_data;
        logic       nibble_tick;
    } mfo_tx_ev_s;

    // Receive preamble octets from the MAC core
    typedef struct packed {
        logic       valid;
        logic [7:0] octet;
        logic       err;
        logic       sfd;
    } mfo_rx_pre_s;

endpackage : mfo_pkg

// [logic/mfo_frame_option.sv]
// MAC frame option configuration: APB registers plus the frame decisions they steer
// Operation
// - Defer control set means defer forever; clear means abort at deferral limit.
// - Backpressure skip set retries at once after self-caused backpressure collision.
// - Collision skip set retries at once; clear applies exponential backoff.
// - Length check accepts only receive preambles shorter than 12 octets.
// - Content check discards frames with any preamble octet not 0x55 or errored.
// - Pad detect classifies frame tagged when octets after source equal 0x8100.
// - Tagged pad control is ignored while padding is off; pad detect still drives frame_tagged.
// - Minimum gap after each transmitted packet comes from a 7-bit nibble field.
// - 16-bit and 32-bit accesses work on all aliases; 8-bit ones are ignored.
// - Unimplemented configuration bits read as zero.
//
// Design decisions made here: the APB slave port and the register addresses.
`include "mfo_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module mfo_frame_option
    import mfo_pkg::*;
(
    // Clock, reset, clock enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [5:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // MAC core events
    input  wire mfo_tx_ev_s  tx_ev,
    input  wire mfo_rx_pre_s rx_pre,
    // Decisions to the MAC core
    output logic             tx_abort,
    output logic             retry_immediate,
    output logic             retry_backoff,
    output logic             rx_drop,
    output mfo_pad_e         pad_mode,
    output logic             frame_tagged,
    output logic             checksum_append_on,
    output logic             gap_open,
    // Interrupt
    output logic             irq
);

    // ----------------------------------------------------------------
    // Register storage and bus decode
    // ----------------------------------------------------------------
    logic [31:0] cfg_q;
    logic [31:0] gap_q;
    logic [31:0] stat_q;
    logic [31:0] mask_q;
    logic [2:0]  ev_set;

    logic        access;
    logic        done;
    logic        size_ok;
    logic        hit_cfg;
    logic        hit_gap;
    logic        hit_stat;
    logic        hit_mask;
    logic        mapped;
    logic [31:0] lane_mask;
    mfo_alias_e  alias_sel;

    // Named views of the configuration bits
    logic defer_without_limit;
    logic backpressure_skip_backoff;
    logic collision_skip_backoff;
    logic preamble_length_check;
    logic preamble_content_check;
    logic frame_type_pad_detect;
    logic tagged_frame_pad;
    logic padding_on;
    logic duplex_select;
    logic [6:0] transmit_gap_field;

    assign defer_without_limit       = cfg_q[`MFO_B_DEFER_NOLIM];
    assign backpressure_skip_backoff = cfg_q[`MFO_B_BP_SKIP];
    assign collision_skip_backoff    = cfg_q[`MFO_B_COL_SKIP];
    assign preamble_length_check     = cfg_q[`MFO_B_PRE_LEN];
    assign preamble_content_check    = cfg_q[`MFO_B_PRE_PURE];
    assign frame_type_pad_detect     = cfg_q[`MFO_B_PAD_DETECT];
    assign tagged_frame_pad          = cfg_q[`MFO_B_PAD_TAGGED];
    assign padding_on                = cfg_q[`MFO_B_PAD_ON];
    assign duplex_select             = cfg_q[`MFO_B_DUPLEX];
    assign transmit_gap_field        = gap_q[6:0];

    // Access phase completes on the cycle pready is high
    assign access    = psel & penable;
    assign done      = access & pready;
    assign alias_sel = mfo_alias_e'(paddr[3:2]);
    assign hit_cfg   = (paddr[5:4] == `MFO_OFS_CFG >> 4);
    assign hit_gap   = (paddr[5:4] == `MFO_OFS_GAP >> 4);
    assign hit_stat  = (paddr == `MFO_OFS_IRQ_STAT);
    assign hit_mask  = (paddr == `MFO_OFS_IRQ_MASK);
    assign mapped    = (paddr[1:0] == 2'b00) & (hit_cfg | hit_gap | hit_stat | hit_mask);

    // Word or aligned halfword strobes only; byte writes are ignored
    assign size_ok   = (pstrb == 4'b1111) | (pstrb == 4'b0011) | (pstrb == 4'b1100);
    assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // Alias arithmetic: only bits written as one move under set, clear, invert
    function automatic logic [31:0] apply_alias(input logic [31:0] old_v,
                                                input logic [31:0] wd,
                                                input logic [31:0] m,
                                                input mfo_alias_e  al,
                                                input logic [31:0] impl);
        logic [31:0] r;
        r = old_v;
        case (al)
            MFO_AL_WRITE: r = (old_v & ~m) | (wd & m);
            MFO_AL_CLEAR: r = old_v & ~(wd & m);
            MFO_AL_SET:   r = old_v | (wd & m);
            MFO_AL_INV:   r = old_v ^ (wd & m);
            default:      r = old_v;
        endcase
        return r & impl;
    endfunction

    // ----------------------------------------------------------------
    // APB handshake: one wait state, answer registered
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            if (access & ~pready & ~pwrite) begin
                if (hit_cfg && mapped) begin
                    prdata <= cfg_q;
                end else if (hit_gap && mapped) begin
                    prdata <= gap_q;
                end else if (hit_stat) begin
                    prdata <= stat_q;
                end else if (hit_mask) begin
                    prdata <= mask_q;
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end

    // Configuration register with its three aliases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `MFO_CFG_RESET;
        end else if (ce && done && pwrite && size_ok && hit_cfg && mapped) begin
            cfg_q <= apply_alias(cfg_q, pwdata, lane_mask, alias_sel, `MFO_CFG_IMPL);
        end
    end

    // Gap register with its three aliases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= `MFO_GAP_RESET;
        end else if (ce && done && pwrite && size_ok && hit_gap && mapped) begin
            gap_q <= apply_alias(gap_q, pwdata, lane_mask, alias_sel, `MFO_GAP_IMPL);
        end
    end

    // Interrupt mask, plain write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 32'h0000_0000;
        end else if (ce && done && pwrite && size_ok && hit_mask) begin
            mask_q <= ((mask_q & ~lane_mask) | (pwdata & lane_mask)) & `MFO_IRQ_IMPL;
        end
    end

    // Sticky status: a read clears only the bits it returned, so a set wins
    assign ev_set = {retry_immediate, rx_drop, tx_abort};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 32'h0000_0000;
        end else if (ce) begin
            if (done && !pwrite && hit_stat) begin
                stat_q <= (stat_q & ~prdata) | {29'h0000_0000, ev_set};
            end else begin
                stat_q <= stat_q | {29'h0000_0000, ev_set};
            end
        end
    end

    // Level interrupt from the unmasked sticky bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(stat_q & mask_q);
        end
    end

    // ----------------------------------------------------------------
    // Deferral and collision decisions
    // ----------------------------------------------------------------
    // One-cycle pulses, one cycle after the core event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_abort        <= 1'b0;
            retry_immediate <= 1'b0;
            retry_backoff   <= 1'b0;
        end else if (ce) begin
            tx_abort        <= tx_ev.defer_limit & ~defer_without_limit;
            retry_immediate <= tx_ev.collision &
                               (collision_skip_backoff |
                                (backpressure_skip_backoff & tx_ev.backpressure));
            retry_backoff   <= tx_ev.collision & ~collision_skip_backoff &
                               ~(backpressure_skip_backoff & tx_ev.backpressure);
        end
    end

    // ----------------------------------------------------------------
    // Receive preamble checks
    // ----------------------------------------------------------------
    logic [3:0] pre_len_q;
    logic       pre_bad_q;

    // Length saturates so long preambles cannot wrap back to legal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_len_q <= 4'h0;
            pre_bad_q <= 1'b0;
        end else if (ce) begin
            if (rx_pre.sfd) begin
                pre_len_q <= 4'h0;
                pre_bad_q <= 1'b0;
            end else if (rx_pre.valid) begin
                if (pre_len_q != `MFO_PRE_MAX_LEN) begin
                    pre_len_q <= pre_len_q + 4'h1;
                end
                if (rx_pre.err || rx_pre.octet != `MFO_PRE_OCTET) begin
                    pre_bad_q <= 1'b1;
                end
            end
        end
    end

    // Verdict taken when the frame delimiter ends the preamble
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_drop <= 1'b0;
        end else if (ce) begin
            rx_drop <= rx_pre.sfd &
                       ((preamble_length_check & (pre_len_q == `MFO_PRE_MAX_LEN)) |
                        (preamble_content_check & pre_bad_q));
        end
    end

    // ----------------------------------------------------------------
    // Tagged frame detection and pad selection
    // ----------------------------------------------------------------
    logic [3:0] tx_pos_q;
    logic       tag_hi_q;
    logic       tagged_q;

    // Octet position counter saturates past the type field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pos_q <= 4'h0;
            tag_hi_q <= 1'b0;
            tagged_q <= 1'b0;
        end else if (ce) begin
            if (tx_ev.sof) begin
                tx_pos_q <= 4'h0;
                tag_hi_q <= 1'b0;
                tagged_q <= 1'b0;
            end else if (tx_ev.byte_valid && tx_pos_q != 4'hF) begin
                tx_pos_q <= tx_pos_q + 4'h1;
                if (tx_pos_q == `MFO_TAG_POS_HI) begin
                    tag_hi_q <= (tx_ev.byte_data == `MFO_TAG_HI);
                end
                if (tx_pos_q == `MFO_TAG_POS_LO) begin
                    tagged_q <= tag_hi_q & (tx_ev.byte_data == `MFO_TAG_LO);
                end
            end
        end
    end

    // Pad mode: detection counts only while enabled; all needs padding on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_mode     <= MFO_PAD_UNTAGGED;
            frame_tagged <= 1'b0;
        end else if (ce) begin
            frame_tagged <= frame_type_pad_detect & tagged_q;
            if (!padding_on) begin
                pad_mode <= MFO_PAD_NONE;
            end else if (frame_type_pad_detect) begin
                pad_mode <= tagged_q ? MFO_PAD_TAGGED : MFO_PAD_UNTAGGED;
            end else if (tagged_frame_pad) begin
                pad_mode <= MFO_PAD_TAGGED;
            end else begin
                pad_mode <= MFO_PAD_UNTAGGED;
            end
        end
    end

    // Checksum append as a registered level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            checksum_append_on <= 1'b1;
        end else if (ce) begin
            checksum_append_on <= cfg_q[`MFO_B_CRC_ON];
        end
    end

    // ----------------------------------------------------------------
    // Back-to-back interpacket gap
    // ----------------------------------------------------------------
    logic [7:0] gap_cnt_q;
    logic [7:0] gap_load;

    // Field plus duplex offset gives the gap in nibble times
    assign gap_load = {1'b0, transmit_gap_field} +
                      (duplex_select ? `MFO_GAP_ADD_FULL : `MFO_GAP_ADD_HALF);

    // Counter loads at packet end and counts nibble ticks to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt_q <= 8'h00;
        end else if (ce) begin
            if (tx_ev.eof) begin
                gap_cnt_q <= gap_load;
            end else if (tx_ev.nibble_tick && gap_cnt_q != 8'h00) begin
                gap_cnt_q <= gap_cnt_q - 8'h01;
            end
        end
    end

    // Gap open only once the whole count has elapsed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_open <= 1'b1;
        end else if (ce) begin
            gap_open <= ~tx_ev.eof & ((gap_cnt_q == 8'h00) |
                        ((gap_cnt_q == 8'h01) & tx_ev.nibble_tick));
        end
    end

endmodule // mfo_frame_option

`default_nettype wire

// [dv/mfo_frame_option_properties.sv]
// Concurrent checks on the ports of the MAC frame option block
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module mfo_frame_option_checker
    import mfo_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    // APB answer
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    // Core side
    input wire mfo_tx_ev_s  tx_ev,
    input wire mfo_rx_pre_s rx_pre,
    input wire logic        tx_abort,
    input wire logic        retry_immediate,
    input wire logic        retry_backoff,
    input wire logic        rx_drop,
    input wire mfo_pad_e    pad_mode,
    input wire logic        gap_open
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Steps of an APB answer and a collision
    sequence s_access;
        psel && penable && !pready && ce;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    sequence s_collide;
        ce && tx_ev.collision;
    endsequence
    // Bus answer: one wait state, a single-cycle strobe
    AST_APB_ANSWER: assert property (s_access |=> s_answer)
        else $error("bad pready");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("stray pslverr");
    // Transmit and receive decisions follow their cause by one cycle
    AST_ABORT_CAUSE: assert property (tx_abort |-> $past(tx_ev.defer_limit && ce))
        else $error("stray abort");
    AST_RETRY_ONE: assert property (s_collide |=> retry_immediate ^ retry_backoff)
        else $error("bad retry kind");
    AST_RETRY_CAUSE: assert property ((retry_immediate || retry_backoff)
        |-> $past(tx_ev.collision))
        else $error("stray retry");
    AST_DROP_CAUSE: assert property (rx_drop |-> $past(rx_pre.sfd))
        else $error("stray drop");
    // Gap closes on end of frame and reopens only on a nibble tick
    AST_GAP_CLOSE: assert property (ce && tx_ev.eof |=> !gap_open)
        else $error("gap not closed");
    AST_GAP_OPEN: assert property ($rose(gap_open)
        |-> $past(tx_ev.nibble_tick) || $past(tx_ev.nibble_tick, 2))
        else $error("gap early");
    AST_PAD_CODE: assert property (pad_mode != 2'b11)
        else $error("bad pad code");
endmodule // mfo_frame_option_checker

bind mfo_frame_option mfo_frame_option_checker u_chk (.pclk, .presetn, .ce, .psel, .penable,
    .pready, .pslverr, .tx_ev, .rx_pre, .tx_abort, .retry_immediate, .retry_backoff, .rx_drop,
    .pad_mode, .gap_open);
`default_nettype wire

// [dv/mfo_core_model.sv]
// Behavioural MAC core that feeds transmit events and receive preamble octets
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Core model
// ----------------------------------------------------------------
module mfo_core_model
    import mfo_pkg::*;
(
    // Clock
    input  wire logic      pclk,
    // Event streams
    output var mfo_tx_ev_s  tx_ev,
    output var mfo_rx_pre_s rx_pre
);
    // Quiet at time zero
    initial begin
        tx_ev = '0;
        rx_pre = '0;
    end
    // One-cycle event; idle data shows the inverse so stale octets never match
    task automatic tx(input mfo_tx_ev_s v);
        mfo_tx_ev_s z;
        z = '0;
        z.byte_data = ~v.byte_data;
        @(posedge pclk);
        tx_ev <= v;
        @(posedge pclk);
        tx_ev <= z;
    endtask
    // One preamble octet or end marker
    task automatic rx(input mfo_rx_pre_s v);
        mfo_rx_pre_s z;
        z = '0;
        z.octet = ~v.octet;
        @(posedge pclk);
        rx_pre <= v;
        @(posedge pclk);
        rx_pre <= z;
    endtask
endmodule // mfo_core_model
`default_nettype wire

// [dv/mfo_frame_option_tb.sv]
// Self-checking bench for the MAC frame option block
`include "mfo_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module mfo_frame_option_tb
    import mfo_pkg::*;
;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
    logic [5:0]  paddr;
    logic [31:0] pwdata, prdata, rd, cfg_m, gap_m, d;
    logic [3:0]  pstrb;
    logic        tx_abort, retry_immediate, retry_backoff, rx_drop, frame_tagged;
    logic        checksum_append_on, gap_open, irq, e;
    logic [3:0]  kk;
    logic [7:0]  g;
    mfo_pad_e    pad_mode;
    mfo_tx_ev_s  tx_ev, ev;
    mfo_rx_pre_s rx_pre, p;
    int          miscompares, check_count, i, j, n;
    integer      seed;
    logic [3:0]  st [5] = '{4'hF, 4'h3, 4'hC, 4'h1, 4'h8};
    int          pn [6] = '{12, 11, 12, 8, 8, 8};
    int          pb [6] = '{0, 0, 0, 1, 2, 1};
    logic [1:0]  pc [6] = '{2'b10, 2'b10, 2'b00, 2'b01, 2'b01, 2'b00};
    // ------------------------------------------------------------
    // Clock, design and core model
    // ------------------------------------------------------------
    always #5 pclk = ~pclk;
    mfo_frame_option uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .tx_ev, .rx_pre, .tx_abort, .retry_immediate,
        .retry_backoff, .rx_drop, .pad_mode, .frame_tagged, .checksum_append_on, .gap_open,
        .irq);
    mfo_core_model core (.pclk, .tx_ev, .rx_pre);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("check_count %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // APB transfer held until pready is sampled high
    task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] wd,
                       input logic [3:0] s);
        int k;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, wd, s};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Register image after a write; odd strobes leave it untouched
    function automatic logic [31:0] wexp(logic [31:0] o, logic [31:0] w, logic [3:0] s,
                                          mfo_alias_e al, logic [31:0] impl);
        logic [31:0] m;
        m = {{16{s[3]}}, {16{s[0]}}};
        if (!(s inside {4'hF, 4'h3, 4'hC})) return o;
        case (al)
            MFO_AL_WRITE: o = (o & ~m) | (w & m);
            MFO_AL_CLEAR: o = o & ~(w & m);
            MFO_AL_SET:   o = o | (w & m);
            default:      o = o ^ (w & m);
        endcase
        return o & impl;
    endfunction
    function automatic mfo_pad_e pexp(logic [3:0] c);
        if (!c[0]) return MFO_PAD_NONE;
        if (c[2]) return c[3] ? MFO_PAD_TAGGED : MFO_PAD_UNTAGGED;
        return c[1] ? MFO_PAD_TAGGED : MFO_PAD_UNTAGGED;
    endfunction
    // Hang guard
    initial begin
        #800000;
        miscompares++;
        stop_test();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        ce = 1'b1;
        miscompares = 0;
        check_count = 0;
        seed = 32'h854c;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk(pad_mode, MFO_PAD_UNTAGGED);
        chk(gap_open, 1'b1);
        apb(0, `MFO_OFS_CFG, 0, 4'hF);
        chk(rd, `MFO_CFG_RESET);
        apb(0, `MFO_OFS_GAP, 0, 4'hF);
        chk(rd, `MFO_GAP_RESET);
        apb(1, 6'h30, 32'hFFFF_FFFF, 4'hF);
        chk(er, 1'b1);
        apb(0, 6'h30, 0, 4'hF);
        chk({er, rd}, {1'b1, 32'h0});
        cfg_m = `MFO_CFG_RESET;
        gap_m = `MFO_GAP_RESET;
        // Random alias writes of every width, each read back
        for (i = 0; i < 20; i++) begin
            g = $random(seed);
            d = $random(seed);
            kk = st[g[7:5] % 5];
            apb(1, {1'b0, g[4], g[3:2], 2'b00}, d, kk);
            if (g[4]) gap_m = wexp(gap_m, d, kk, mfo_alias_e'(g[3:2]), `MFO_GAP_IMPL);
            else cfg_m = wexp(cfg_m, d, kk, mfo_alias_e'(g[3:2]), `MFO_CFG_IMPL);
            apb(0, {1'b0, g[4], 4'h0}, 0, 4'hF);
            chk(rd, g[4] ? gap_m : cfg_m);
        end
        chk(checksum_append_on, cfg_m[4]);
        // Gap length: recommended full and half settings, then a random one
        for (i = 0; i < 3; i++) begin
            g = $random(seed);
            e = (i == 0) || (i == 2 && g[7]);
            d = (i == 0) ? 32'h15 : (i == 1) ? 32'h12 : {25'h0, g[6:0]};
            apb(1, `MFO_OFS_CFG, 32'h20 | e, 4'hF);
            apb(1, `MFO_OFS_GAP, d, 4'hF);
            n = d + (e ? 3 : 6);
            ev = '0;
            ev.eof = 1'b1;
            core.tx(ev);
            #1 chk(gap_open, 1'b0);
            ev = '0;
            ev.nibble_tick = 1'b1;
            repeat (n - 1) core.tx(ev);
            repeat (2) @(posedge pclk);
            #1 chk(gap_open, 1'b0);
            core.tx(ev);
            @(posedge pclk);
            #1 chk(gap_open, 1'b1);
        end
        // Collision for every skip and backpressure case, deferral limit with both defer settings
        for (i = 0; i < 8; i++) begin
            kk = i;
            apb(1, `MFO_OFS_CFG, 32'h20 | (kk[1:0] << 12) | (kk[0] << 14), 4'hF);
            ev = '0;
            ev.collision = 1'b1;
            ev.backpressure = kk[2];
            ev.defer_limit = kk[1];
            core.tx(ev);
            e = kk[0] | (kk[1] & kk[2]);
            #1 chk({retry_immediate, retry_backoff}, {e, !e});
            chk(tx_abort, kk[1] & !kk[0]);
        end
        // Interrupt: masked stays low, unmasked rises, read clears
        apb(0, `MFO_OFS_IRQ_STAT, 0, 4'hF);
        apb(1, `MFO_OFS_CFG, 32'h1020, 4'hF);
        ev = '0;
        ev.collision = 1'b1;
        core.tx(ev);
        repeat (3) @(posedge pclk);
        #1 chk(irq, 1'b0);
        apb(1, `MFO_OFS_IRQ_MASK, 32'h4, 4'hF);
        repeat (2) @(posedge pclk);
        #1 chk(irq, 1'b1);
        apb(0, `MFO_OFS_IRQ_STAT, 0, 4'hF);
        chk(rd, 32'h4);
        repeat (2) @(posedge pclk);
        #1 chk(irq, 1'b0);
        // Preamble length and content checks
        for (i = 0; i < 6; i++) begin
            apb(1, `MFO_OFS_CFG, 32'h20 | (pc[i] << 8), 4'hF);
            for (j = 0; j < pn[i]; j++) begin
                p = '{1'b1, (pb[i] == 1 && j == 3) ? 8'h54 : `MFO_PRE_OCTET,
                      pb[i] == 2 && j == 3, 1'b0};
                core.rx(p);
            end
            p = '0;
            p.sfd = 1'b1;
            core.rx(p);
            #1 chk(rx_drop, (pc[i][1] && pn[i] >= 12) || (pc[i][0] && pb[i] != 0));
        end
        // Padding for every control combination
        for (i = 0; i < 16; i++) begin
            kk = i;
            apb(1, `MFO_OFS_CFG, {24'h0, kk[2:0], 5'h0}, 4'hF);
            ev = '0;
            ev.sof = 1'b1;
            core.tx(ev);
            for (j = 0; j < 14; j++) begin
                ev = '0;
                ev.byte_valid = 1'b1;
                g = $random(seed);
                ev.byte_data = (j == 12) ? (kk[3] ? `MFO_TAG_HI : 8'h88) : (j == 13) ? 8'h00 : g;
                core.tx(ev);
            end
            repeat (2) @(posedge pclk);
            #1 chk(pad_mode, pexp(kk));
            if (kk[2]) chk(frame_tagged, kk[3]);
        end
        stop_test();
    end
endmodule // mfo_frame_option_tb
`default_nettype wire
